// ---- sim/test_temp_monitor_config_control.sv ----
// self-checking bench for the configuration block
module test_temp_monitor_config_control;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic alert_flags_i = 1'b0;
	logic remote_over_flag_i = 1'b0;
	logic local_over_flag_i = 1'b0;
	logic reg_wr_i, reg_rd_i;
	logic [7:0] reg_ptr_i, reg_wdata_i, reg_rdata_o, q;
	logic alert_n_o, busy_o, series_resist_fix_o, ext_range_o;
	logic [1:0] chan_o;
	logic [1:0] fch = 2'h0;
	int errors = 0;
	int n_checks = 0;
	int nbusy = 0;
	int cyc = 0;
	int nidle = 0;
	int gap = 0;
	logic [2:0] conv_rate_i = 3'h7;

	tmcc_top #(.DUAL_REMOTE(1'b1), .CONV_CYC(4), .RATE_UNIT(2))
	tmcc_top_i (.core_clk_i, .rstn_i, .reg_wr_i, .reg_rd_i,
		.reg_ptr_i, .reg_wdata_i, .reg_rdata_o, .alert_flags_i,
		.remote_over_flag_i, .local_over_flag_i,
		.conv_rate_i, .alert_n_o, .busy_o, .chan_o,
		.series_resist_fix_o, .ext_range_o);

	tmcc_host tmcc_host_i (.clk_i(core_clk_i), .wr_o(reg_wr_i),
		.rd_o(reg_rd_i), .ptr_o(reg_ptr_i), .wd_o(reg_wdata_i),
		.rdata_i(reg_rdata_o));

	initial begin
		forever #5 core_clk_i = ~core_clk_i;
	end

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	task automatic wreg(input logic [7:0] p, d);
		tmcc_host_i.acc(1'b1, p, d, q);
	endtask

	task automatic rchk(input logic [7:0] p, e);
		tmcc_host_i.acc(1'b0, p, 8'h00, q);
		chk(q, e);
	endtask

	// one-shot: busy cycle count and first channel
	task automatic shot(input logic [7:0] n, input logic [1:0] c);
		nbusy = 0;
		wreg(8'h0F, 8'h00);
		tick(40);
		chk(8'(nbusy), n);
		chk(8'(fch), 8'(c));
	endtask

	// busy cycles and channel at start of a run
	always @(posedge core_clk_i) begin
		cyc++;
		if (busy_o === 1'b1) begin
			if (nbusy == 0)
				fch = chan_o;
			nbusy++;
			// idle run that ended here
			if (nidle != 0)
				gap = nidle;
			nidle = 0;
		end else begin
			nidle++;
		end
		if (cyc == 3000) begin
			errors++;
			summarize();
		end
	end

	// --------------------------------------------------------------
	// tests
	// --------------------------------------------------------------
	initial begin
		repeat (6) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		rchk(8'h03, 8'h00);
		rchk(8'h3F, 8'h3C);
		rchk(8'h1A, 8'h00);
		wreg(8'h09, 8'hFF);
		rchk(8'h03, 8'hE4);
		wreg(8'h3F, 8'hFF);
		rchk(8'h3F, 8'h3C);
		wreg(8'h03, 8'h00);
		rchk(8'h03, 8'hE4);
		chk(8'(ext_range_o), 8'h01);
		chk(8'(series_resist_fix_o), 8'h01);
		$display("test registers done");

		wreg(8'h09, 8'h00);
		chk(8'(ext_range_o), 8'h00);
		@(posedge core_clk_i) alert_flags_i <= 1'b1;
		tick(2);
		chk(8'(alert_n_o), 8'h00);
		wreg(8'h09, 8'h80);
		chk(8'(alert_n_o), 8'h01);
		wreg(8'h09, 8'h00);
		chk(8'(alert_n_o), 8'h00);
		@(posedge core_clk_i) alert_flags_i <= 1'b0;
		wreg(8'h09, 8'hA0);
		chk(8'(alert_n_o), 8'h01);
		@(posedge core_clk_i) remote_over_flag_i <= 1'b1;
		tick(2);
		chk(8'(alert_n_o), 8'h00);
		@(posedge core_clk_i) remote_over_flag_i <= 1'b0;
		local_over_flag_i <= 1'b1;
		tick(2);
		chk(8'(alert_n_o), 8'h00);
		@(posedge core_clk_i) local_over_flag_i <= 1'b0;
		tick(2);
		chk(8'(alert_n_o), 8'h01);
		$display("test alert done");

		wreg(8'h09, 8'h40);
		tick(3);
		nbusy = 0;
		tick(30);
		chk(8'(nbusy), 8'h00);
		shot(8'h0C, 2'h0);
		wreg(8'h3F, 8'h34);
		shot(8'h08, 2'h1);
		wreg(8'h3F, 8'h30);
		shot(8'h04, 2'h1);
		chk(8'(series_resist_fix_o), 8'h00);
		wreg(8'h09, 8'h00);
		nbusy = 0;
		tick(30);
		chk(8'(nbusy >= 12), 8'h01);
		// wait is two cycles shifted by seven minus the rate code
		chk(8'(gap), 8'h02);
		@(posedge core_clk_i) conv_rate_i <= 3'h5;
		tick(40);
		chk(8'(gap), 8'h08);
		$display("test sequencer done");
		summarize();
	end
endmodule

// ---- sim/tmcc_host.sv ----
// host model that drives the register port of the block
module tmcc_host (
	// clock
	input wire logic clk_i,
	// register port
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] ptr_o,
	output logic [7:0] wd_o,
	input wire logic [7:0] rdata_i
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		ptr_o = 8'h00;
		wd_o = 8'h00;
	end

	// --------------------------------------------------------------
	// one byte access
	// --------------------------------------------------------------
	// correction cleared only on command, no limits held
	task automatic acc(input logic w, input logic [7:0] p, d,
		output logic [7:0] q);
		@(posedge clk_i);
		wr_o <= w;
		rd_o <= !w;
		ptr_o <= p;
		wd_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		// released lines do not keep the old value
		ptr_o <= ~p;
		wd_o <= ~d;
		@(posedge clk_i);
		#1 q = rdata_i;
	endtask
endmodule

// ---- verilog/tmcc_pkg.sv ----
// constants and types for the temperature monitor configuration block
package tmcc_pkg;

	// ----------------------------------------------------------------
	// pointer addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] PTR_CFG1_RD = 8'h03;
	localparam logic [7:0] PTR_CFG1_WR = 8'h09;
	localparam logic [7:0] PTR_CFG2_ONE = 8'h1A;
	localparam logic [7:0] PTR_CFG2_TWO = 8'h3F;
	// one-shot pointer: arbitrary, a write here while halted and idle starts one sequence
	localparam logic [7:0] PTR_ONESHOT = 8'h0F;

	// ----------------------------------------------------------------
	// first configuration register fields
	// ----------------------------------------------------------------
	localparam int CFG1_MASK_BIT = 7;
	localparam int CFG1_HALT_BIT = 6;
	localparam int CFG1_PINF_BIT = 5;
	localparam int CFG1_RANGE_BIT = 2;
	localparam logic [7:0] CFG1_USED = 8'hE4;
	localparam logic [7:0] CFG1_RESET = 8'h00;

	// ----------------------------------------------------------------
	// second configuration register fields
	// ----------------------------------------------------------------
	localparam int CFG2_EXT2_BIT = 5;
	localparam int CFG2_EXT1_BIT = 4;
	localparam int CFG2_LOC_BIT = 3;
	localparam int CFG2_RFIX_BIT = 2;
	localparam logic [7:0] CFG2_USED_ONE = 8'h1C;
	localparam logic [7:0] CFG2_USED_TWO = 8'h3C;
	localparam logic [7:0] CFG2_RESET_ONE = 8'h1C;
	localparam logic [7:0] CFG2_RESET_TWO = 8'h3C;

	// ----------------------------------------------------------------
	// timing counts
	// ----------------------------------------------------------------
	localparam int CONV_CYC_DEF = 64;
	localparam int RATE_UNIT_DEF = 16;
	localparam logic [2:0] RATE_MAX = 3'h7;

	// ----------------------------------------------------------------
	// conversion sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SEQ_HALT = 3'b000,
		SEQ_LOC = 3'b001,
		SEQ_EXT1 = 3'b010,
		SEQ_EXT2 = 3'b011,
		SEQ_WAIT = 3'b100
	} tmcc_seq_t;

endpackage

// ---- verilog/tmcc_top.sv ----
// configuration registers, pin function and conversion sequencer
//
// Function
// - config one written at 09h, read at 03h
// - mask bit holds alert pin high
// - mask ignored in over-temperature pin function
// - mask change reaches pin at once
// - halt clear gives continuous rate-paced conversions
// - halt set stops at once; clear resumes
// - one-shot write while halted runs one sequence
// - pin function clear gives interrupt alert output
// - pin function set follows over-limit flags
// - range bit selects standard or extended format
// - reserved zero written; register resets to zero
// - config two at variant-dependent single address
// - correction bit on; off halves conversion time
// - local enable includes on-chip sensor
// - external enables; channel two dual variant only
// - local, ext1, ext2, then rate wait, skip disabled
// - config two reset 1Ch or 3Ch
// - rising latched flag drives alert low
module tmcc_top #(
	parameter bit DUAL_REMOTE = 1'b1,
	parameter int CONV_CYC = tmcc_pkg::CONV_CYC_DEF,
	parameter int RATE_UNIT = tmcc_pkg::RATE_UNIT_DEF
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_ptr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// status flags from the limit logic
	input wire logic alert_flags_i,
	input wire logic remote_over_flag_i,
	input wire logic local_over_flag_i,
	// conversion rate code
	input wire logic [2:0] conv_rate_i,
	// pin and measurement control
	output logic alert_n_o,
	output logic busy_o,
	output logic [1:0] chan_o,
	output logic series_resist_fix_o,
	output logic ext_range_o
);

	// ----------------------------------------------------------------
	// variant constants
	// ----------------------------------------------------------------
	localparam logic [7:0] PTR_CFG2 =
		DUAL_REMOTE ? tmcc_pkg::PTR_CFG2_TWO : tmcc_pkg::PTR_CFG2_ONE;
	localparam logic [7:0] CFG2_USED =
		DUAL_REMOTE ? tmcc_pkg::CFG2_USED_TWO : tmcc_pkg::CFG2_USED_ONE;
	localparam logic [7:0] CFG2_RST =
		DUAL_REMOTE ? tmcc_pkg::CFG2_RESET_TWO : tmcc_pkg::CFG2_RESET_ONE;
	localparam logic [31:0] CONV_FULL = 32'(CONV_CYC);
	localparam logic [31:0] CONV_HALF = 32'((CONV_CYC + 1) / 2);
	localparam logic [31:0] RATE_BASE = 32'(RATE_UNIT);
	// longest one-shot: three channels plus entry and exit
	localparam int SHOT_MAX = 3 * CONV_CYC + 2;

	// ----------------------------------------------------------------
	// next enabled channel at or after a position
	// ----------------------------------------------------------------
	function automatic tmcc_pkg::tmcc_seq_t next_chan(
		input logic [1:0] from,
		input logic [2:0] en
	);
		tmcc_pkg::tmcc_seq_t r;
		r = tmcc_pkg::SEQ_WAIT;
		if (from <= 2'h2 && en[2]) begin
			r = tmcc_pkg::SEQ_EXT2;
		end
		if (from <= 2'h1 && en[1]) begin
			r = tmcc_pkg::SEQ_EXT1;
		end
		if (from == 2'h0 && en[0]) begin
			r = tmcc_pkg::SEQ_LOC;
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [7:0] cfg1_q, cfg1_d;
	logic [7:0] cfg2_q, cfg2_d;
	logic [7:0] rdata_q, rdata_d;
	tmcc_pkg::tmcc_seq_t seq_q, seq_d;
	logic [31:0] tmr_q, tmr_d;
	logic oneshot_q, oneshot_d;
	logic flags_q;
	logic alert_st_q, alert_st_d;
	logic alert_n_q, alert_n_d;
	logic busy_q, busy_d;
	logic [1:0] chan_q, chan_d;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire wr_cfg1 = reg_wr_i && reg_ptr_i == tmcc_pkg::PTR_CFG1_WR;
	wire wr_cfg2 = reg_wr_i && reg_ptr_i == PTR_CFG2;
	wire wr_shot = reg_wr_i && reg_ptr_i == tmcc_pkg::PTR_ONESHOT;
	wire rd_cfg1 = reg_ptr_i == tmcc_pkg::PTR_CFG1_RD;
	wire rd_cfg2 = reg_ptr_i == PTR_CFG2;

	wire mask_bit = cfg1_q[tmcc_pkg::CFG1_MASK_BIT];
	wire halt_bit = cfg1_q[tmcc_pkg::CFG1_HALT_BIT];
	wire pinf_bit = cfg1_q[tmcc_pkg::CFG1_PINF_BIT];
	wire [2:0] chan_en = {
		cfg2_q[tmcc_pkg::CFG2_EXT2_BIT],
		cfg2_q[tmcc_pkg::CFG2_EXT1_BIT],
		cfg2_q[tmcc_pkg::CFG2_LOC_BIT]
	};
	wire rfix_bit = cfg2_q[tmcc_pkg::CFG2_RFIX_BIT];

	// ----------------------------------------------------------------
	// register writes and reads
	// ----------------------------------------------------------------
	// write port and read view
	assign cfg1_d = wr_cfg1 ? (reg_wdata_i & tmcc_pkg::CFG1_USED) : cfg1_q;
	// ext2 kept only on dual variant
	assign cfg2_d = wr_cfg2 ? (reg_wdata_i & CFG2_USED) : cfg2_q;
	assign rdata_d = !reg_rd_i ? rdata_q :
		rd_cfg1 ? cfg1_q :
		rd_cfg2 ? cfg2_q : 8'h00;

	// ----------------------------------------------------------------
	// alert pin
	// ----------------------------------------------------------------
	// rising flag sets alert state
	assign alert_st_d = (alert_flags_i && !flags_q) ? 1'b1 :
		(alert_flags_i ? alert_st_q : 1'b0);
	assign alert_n_d = pinf_bit ?
		!(remote_over_flag_i || local_over_flag_i) :
		!(alert_st_d && !mask_bit);

	// ----------------------------------------------------------------
	// conversion sequencer
	// ----------------------------------------------------------------
	// correction off halves conversion time
	wire [31:0] conv_len = rfix_bit ? CONV_FULL : CONV_HALF;
	wire [31:0] wait_len = RATE_BASE << (tmcc_pkg::RATE_MAX - conv_rate_i);
	wire tmr_done = tmr_q <= 32'h0000_0001;

	always_comb begin
		seq_d = seq_q;
		tmr_d = tmr_done ? 32'h0000_0000 : tmr_q - 32'h0000_0001;
		oneshot_d = oneshot_q;
		case (seq_q)
			tmcc_pkg::SEQ_HALT: begin
				tmr_d = 32'h0000_0000;
				if (!halt_bit || wr_shot) begin
					oneshot_d = halt_bit;
					seq_d = next_chan(2'h0, chan_en);
					tmr_d = (seq_d == tmcc_pkg::SEQ_WAIT) ?
						wait_len : conv_len;
				end
			end
			tmcc_pkg::SEQ_LOC, tmcc_pkg::SEQ_EXT1, tmcc_pkg::SEQ_EXT2: begin
				if (tmr_done) begin
					// next enabled channel in order
					// state code is one past its own position
					seq_d = next_chan(seq_q[1:0], chan_en);
					tmr_d = (seq_d == tmcc_pkg::SEQ_WAIT) ?
						wait_len : conv_len;
					// back to halt after one sequence
					if (seq_d == tmcc_pkg::SEQ_WAIT && oneshot_q) begin
						seq_d = tmcc_pkg::SEQ_HALT;
						oneshot_d = 1'b0;
					end
				end
			end
			tmcc_pkg::SEQ_WAIT: begin
				// one-shot with no channel enabled ends here
				if (oneshot_q) begin
					seq_d = tmcc_pkg::SEQ_HALT;
					oneshot_d = 1'b0;
					tmr_d = 32'h0000_0000;
				end else if (tmr_done) begin
					seq_d = next_chan(2'h0, chan_en);
					tmr_d = (seq_d == tmcc_pkg::SEQ_WAIT) ?
						wait_len : conv_len;
				end
			end
			default: begin
				seq_d = tmcc_pkg::SEQ_HALT;
				tmr_d = 32'h0000_0000;
			end
		endcase
		// halt stops continuous conversion at once
		if (halt_bit && !oneshot_q && seq_q != tmcc_pkg::SEQ_HALT) begin
			seq_d = tmcc_pkg::SEQ_HALT;
			tmr_d = 32'h0000_0000;
		end
	end

	assign busy_d = seq_d == tmcc_pkg::SEQ_LOC ||
		seq_d == tmcc_pkg::SEQ_EXT1 || seq_d == tmcc_pkg::SEQ_EXT2;
	assign chan_d = busy_d ? seq_d[1:0] - 2'h1 : 2'h0;

	// ----------------------------------------------------------------
	// flip-flops
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			cfg1_q <= tmcc_pkg::CFG1_RESET;
			cfg2_q <= CFG2_RST;
			rdata_q <= 8'h00;
			seq_q <= tmcc_pkg::SEQ_HALT;
			tmr_q <= 32'h0000_0000;
			oneshot_q <= 1'b0;
			flags_q <= 1'b0;
			alert_st_q <= 1'b0;
			alert_n_q <= 1'b1;
			busy_q <= 1'b0;
			chan_q <= 2'h0;
		end else begin
			cfg1_q <= cfg1_d;
			cfg2_q <= cfg2_d;
			rdata_q <= rdata_d;
			seq_q <= seq_d;
			tmr_q <= tmr_d;
			oneshot_q <= oneshot_d;
			flags_q <= alert_flags_i;
			alert_st_q <= alert_st_d;
			alert_n_q <= alert_n_d;
			busy_q <= busy_d;
			chan_q <= chan_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign alert_n_o = alert_n_q;
	assign busy_o = busy_q;
	assign chan_o = chan_q;
	assign series_resist_fix_o = rfix_bit;
	assign ext_range_o = cfg1_q[tmcc_pkg::CFG1_RANGE_BIT];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_CFG1_READ: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		reg_wr_i && reg_ptr_i == tmcc_pkg::PTR_CFG1_WR ##1
		(!reg_wr_i) [*2] ##1
		reg_rd_i && !reg_wr_i && reg_ptr_i == tmcc_pkg::PTR_CFG1_RD
		|=> reg_rdata_o == ($past(reg_wdata_i, 4) & tmcc_pkg::CFG1_USED))
		else $error("config one readback differs from write");
	AST_MASK_HIGH: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		cfg1_q[tmcc_pkg::CFG1_MASK_BIT] && !cfg1_q[tmcc_pkg::CFG1_PINF_BIT]
		|=> alert_n_o)
		else $error("masked alert pin went low");
	AST_OVERTEMP_OUT_NOMASK: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		cfg1_q[tmcc_pkg::CFG1_PINF_BIT] && remote_over_flag_i
		|=> !alert_n_o)
		else $error("over-temperature pin not low");
	AST_ALERT_RISE: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		!cfg1_q[tmcc_pkg::CFG1_PINF_BIT] && !cfg1_q[tmcc_pkg::CFG1_MASK_BIT]
		&& alert_flags_i && !$past(alert_flags_i) |=> !alert_n_o)
		else $error("alert did not go low on rising flag");
	AST_HALT_STOP: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		cfg1_q[tmcc_pkg::CFG1_HALT_BIT] && !oneshot_q && !wr_shot
		|=> !busy_o)
		else $error("converting while halted");
	AST_RESUME: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		seq_q == tmcc_pkg::SEQ_HALT && !cfg1_q[tmcc_pkg::CFG1_HALT_BIT]
		|=> seq_q != tmcc_pkg::SEQ_HALT)
		else $error("sequencer did not resume");
	AST_ONESHOT: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		seq_q == tmcc_pkg::SEQ_HALT && cfg1_q[tmcc_pkg::CFG1_HALT_BIT]
		&& wr_shot |=> oneshot_q)
		else $error("one-shot not started");
	AST_ORDER: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		seq_q == tmcc_pkg::SEQ_EXT1 && seq_d != tmcc_pkg::SEQ_EXT1
		|-> seq_d != tmcc_pkg::SEQ_LOC)
		else $error("sequence went backwards");
	AST_RESERVED: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(cfg1_q & ~tmcc_pkg::CFG1_USED) == 8'h00
		&& (cfg2_q & ~CFG2_USED) == 8'h00)
		else $error("reserved bit set");
	AST_CFG2_READ: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		reg_wr_i && reg_ptr_i == PTR_CFG2 ##1 (!reg_wr_i) [*2] ##1
		reg_rd_i && !reg_wr_i && reg_ptr_i == PTR_CFG2
		|=> reg_rdata_o == ($past(reg_wdata_i, 4) & CFG2_USED))
		else $error("config two readback differs from write");
	AST_HALT_HOLD: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		seq_q == tmcc_pkg::SEQ_HALT && cfg1_q[tmcc_pkg::CFG1_HALT_BIT]
		&& !wr_shot |=> seq_q == tmcc_pkg::SEQ_HALT)
		else $error("left halt without a one-shot");
	AST_SHOT_END: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		seq_q == tmcc_pkg::SEQ_HALT && cfg1_q[tmcc_pkg::CFG1_HALT_BIT]
		&& wr_shot |-> ##[1:SHOT_MAX] seq_q == tmcc_pkg::SEQ_HALT)
		else $error("one-shot did not return to halt");
	AST_SKIP_LOCAL: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(seq_q == tmcc_pkg::SEQ_HALT || seq_q == tmcc_pkg::SEQ_WAIT)
		&& !cfg2_q[tmcc_pkg::CFG2_LOC_BIT] |=> !busy_o || chan_o != 2'h0)
		else $error("disabled local channel converted");
	AST_CHAN_IDLE: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		!busy_o |-> chan_o == 2'h0)
		else $error("channel code not zero while idle");
	AST_OVER_LOCAL: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		cfg1_q[tmcc_pkg::CFG1_PINF_BIT] && local_over_flag_i |=> !alert_n_o)
		else $error("local over-limit did not pull pin low");
	AST_OVER_CLEAR: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		cfg1_q[tmcc_pkg::CFG1_PINF_BIT] && !remote_over_flag_i
		&& !local_over_flag_i |=> alert_n_o)
		else $error("over-temperature pin low without a flag");
	AST_ALERT_CLEAR: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		!cfg1_q[tmcc_pkg::CFG1_PINF_BIT] && !alert_flags_i |=> alert_n_o)
		else $error("alert pin low with no flag");

endmodule
